// *** verilog/smt_pkg.sv ***
package smt_pkg;
    // ----------------------------------------
    // Clocking of the link
    // ----------------------------------------
    localparam int CORE_PERIOD_NS = 100;
    localparam int CK_DIV = 8;
    localparam int CK_HALF = CK_DIV / 2;
    localparam int CK_PERIOD_NS = CORE_PERIOD_NS * CK_DIV;

    // ----------------------------------------
    // Command and mode encodings
    // ----------------------------------------
    localparam logic [2:0] CMD_DES = 3'h0;
    localparam logic [2:0] CMD_MRS = 3'h1;
    localparam logic [2:0] CMD_REF = 3'h2;
    localparam logic [2:0] CMD_WR = 3'h3;
    localparam logic [2:0] CMD_SYNC = 3'h4;
    localparam int MODE_WL_BIT = 0;
    localparam int MODE_GEAR_BIT = 1;
    localparam int MODE_PDA_BIT = 2;
    localparam int MODE_PERSIST_BIT = 3;
    localparam logic [2:0] OP_MRS = 3'h0;
    localparam logic [2:0] OP_MRS_PDA = 3'h1;
    localparam logic [2:0] OP_WL = 3'h2;
    localparam logic [2:0] OP_GEAR = 3'h3;
    localparam logic [2:0] OP_WR = 3'h4;

    // ----------------------------------------
    // Timing, in nCK unless named _NS, or _CYC for core cycles
    // ----------------------------------------
    localparam int TMOD_NCK = 24;
    localparam int TMRD_PDA_MIN_NCK = 16;
    localparam int TMRD_PDA_NS = 10;
    localparam int TMRD_PDA_NS_NCK = (TMRD_PDA_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
    localparam int TMRD_PDA_NCK = (TMRD_PDA_NS_NCK > TMRD_PDA_MIN_NCK) ? TMRD_PDA_NS_NCK : TMRD_PDA_MIN_NCK;
    localparam int TWLMRD_NCK = 40;
    localparam int TWLDQSEN_NCK = 25;
    localparam int TWL_FB_WAIT_NCK = 4;
    localparam int TSYNC_RAW_NCK = TMOD_NCK + 4;
    localparam int TSYNC_GEAR_NCK = TSYNC_RAW_NCK + (TSYNC_RAW_NCK % 2);
    localparam int TCMD_GEAR_NCK = TMOD_NCK + (TMOD_NCK % 2);
    localparam int TRFC1_NS = 350;
    localparam int TXPR_ADD_NS = 10;
    localparam int TXPR_MIN_NCK = 5;
    localparam int TXPR_NS_NCK = (TRFC1_NS + TXPR_ADD_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
    localparam int TXPR_NCK = (TXPR_NS_NCK > TXPR_MIN_NCK) ? TXPR_NS_NCK : TXPR_MIN_NCK;
    localparam int TRFC1_NCK = (TRFC1_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
    localparam int TCKE_LOW_NCK = 5;
    localparam int PARITY_LATENCY_SLOW = 5;
    localparam int PARITY_LATENCY_FAST = 6;
    localparam int PAR_ALERT_PW_SLOW = 120;
    localparam int PAR_ALERT_PW_FAST = 144;
    localparam int CRC_ALERT_PW = 8;
    localparam int TREFI_NORM_NS = 7800;
    localparam int TREFI_HOT_NS = 3900;
    localparam int TREFI_NORM_CYC = TREFI_NORM_NS / CORE_PERIOD_NS;
    localparam int TREFI_HOT_CYC = TREFI_HOT_NS / CORE_PERIOD_NS;
    localparam int TREFI_MARGIN_CYC = 2 * CK_DIV;
endpackage

// *** verilog/smt_link_if.sv ***
`timescale 1ns/100ps
interface smt_link_if;
    logic ck;
    logic cke;
    logic [2:0] cmd;
    logic [3:0] addr;
    logic par;
    logic dqs;
    logic dqs_oe;
    logic dq_w;
    logic crc;
    logic alert_out;
    logic alert_oe;
    logic alert_n;
    logic dq_fb;
    logic dq_fb_oe;

    // Open-drain alert line with pull-up
    assign alert_n = (alert_oe && !alert_out) ? 1'b0 : 1'b1;

    modport ctrl (output ck, cke, cmd, addr, par, dqs, dqs_oe, dq_w, crc, input alert_n, dq_fb, dq_fb_oe);
    modport dram (input ck, cke, cmd, addr, par, dqs, dqs_oe, dq_w, crc, output alert_out, alert_oe, dq_fb, dq_fb_oe);
endinterface

// *** verilog/smt_sync.sv ***
`timescale 1ns/100ps
module smt_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;

    // --------------------------------------
    // Three stages, change taken when two and three agree
    // --------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++)
        begin : g_bit
            always_ff @(posedge clk_i)
            begin
                if (!rst_b_i)
                begin
                    s1_ff[gi] <= RST_VAL[gi];
                    s2_ff[gi] <= RST_VAL[gi];
                    s3_ff[gi] <= RST_VAL[gi];
                    q_o[gi] <= RST_VAL[gi];
                end
                else
                begin
                    s1_ff[gi] <= d_i[gi];
                    s2_ff[gi] <= s1_ff[gi];
                    s3_ff[gi] <= s2_ff[gi];
                    if (s2_ff[gi] == s3_ff[gi])
                        q_o[gi] <= s3_ff[gi];
                end
            end
        end
    endgenerate
endmodule

// *** verilog/smt_dram.sv ***
`timescale 1ns/100ps
module smt_dram (
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    input wire logic PAR_EN_I,
    input wire logic CRC_EN_I,
    input wire logic FAST_GRADE_I,
    input wire logic DEV_SEL_I,
    smt_link_if.dram LINK,
    output logic WL_MODE_O,
    output logic GEAR_MODE_O,
    output logic PDA_MODE_O,
    output logic PERSIST_MODE_O,
    output logic REF_PULSE_O,
    output logic WR_VALID_O,
    output logic WR_DATA_O,
    output logic PAR_ERR_O,
    output logic CRC_ERR_O
);
    logic [13:0] pin_s;
    logic ck_s, cke_s, par_s, dqs_oe_s, dqs_s, dqw_s, crc_s;
    logic [2:0] cmd_s;
    logic [3:0] addr_s;
    logic ck_d_ff, dqs_d_ff;
    logic ck_rise, dqs_rise, par_bad, cmd_ok;
    logic [3:0] mode_ff;
    logic [3:0] pend_ff;
    logic pend_v_ff;
    logic [7:0] pend_cnt_ff;
    logic [7:0] par_cnt_ff;
    logic [7:0] crc_cnt_ff;
    logic dq_fb_ff;

    // --------------------------------------
    // Pin sampling and edge finding
    // --------------------------------------
    smt_sync #(.W(14), .RST_VAL(14'h0000)) u_sync (
        .clk_i(CORE_CLK_I),
        .rst_b_i(RST_B_I),
        .d_i({LINK.ck, LINK.cke, LINK.cmd, LINK.addr, LINK.par, LINK.dqs_oe, LINK.dqs, LINK.dq_w, LINK.crc}),
        .q_o(pin_s)
    );
    assign {ck_s, cke_s, cmd_s, addr_s, par_s, dqs_oe_s, dqs_s, dqw_s, crc_s} = pin_s;

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_B_I)
        begin
            ck_d_ff <= 1'b0;
            dqs_d_ff <= 1'b0;
        end
        else
        begin
            ck_d_ff <= ck_s;
            dqs_d_ff <= dqs_s;
        end
    end

    assign ck_rise = ck_s && !ck_d_ff;
    assign dqs_rise = dqs_s && !dqs_d_ff && dqs_oe_s; // Strobe counts only while driven
    // Bad parity drops the command; a parity alert in persistent mode blocks all commands
    assign par_bad = PAR_EN_I && ck_rise && cke_s && (par_s != ^{cmd_s, addr_s});
    assign cmd_ok = ck_rise && cke_s && !par_bad && !(mode_ff[smt_pkg::MODE_PERSIST_BIT] && par_cnt_ff != 8'h00);

    // --------------------------------------
    // Mode register set, applied after the update delay
    // --------------------------------------
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_B_I)
        begin
            mode_ff <= 4'h0;
            pend_ff <= 4'h0;
            pend_v_ff <= 1'b0;
            pend_cnt_ff <= 8'h00;
        end
        else if (cmd_ok && cmd_s == smt_pkg::CMD_MRS && (!mode_ff[smt_pkg::MODE_PDA_BIT] || DEV_SEL_I))
        begin
            pend_ff <= addr_s;
            pend_v_ff <= 1'b1;
            pend_cnt_ff <= 8'(smt_pkg::TMOD_NCK - 1);
        end
        else if (pend_v_ff && ck_rise)
        begin
            if (pend_cnt_ff == 8'h00)
            begin
                mode_ff <= pend_ff;
                pend_v_ff <= 1'b0;
            end
            else
                pend_cnt_ff <= pend_cnt_ff - 8'h01;
        end
    end

    // --------------------------------------
    // Alert pulse timers in nCK
    // --------------------------------------
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_B_I)
            par_cnt_ff <= 8'h00;
        else if (par_bad && par_cnt_ff == 8'h00)
            par_cnt_ff <= FAST_GRADE_I ? 8'(smt_pkg::PAR_ALERT_PW_FAST) : 8'(smt_pkg::PAR_ALERT_PW_SLOW);
        else if (ck_rise && par_cnt_ff != 8'h00)
            par_cnt_ff <= par_cnt_ff - 8'h01;
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_B_I)
            crc_cnt_ff <= 8'h00;
        else if (CRC_EN_I && cmd_ok && cmd_s == smt_pkg::CMD_WR && crc_s != dqw_s)
            crc_cnt_ff <= 8'(smt_pkg::CRC_ALERT_PW);
        else if (ck_rise && crc_cnt_ff != 8'h00)
            crc_cnt_ff <= crc_cnt_ff - 8'h01;
    end

    // Drive the alert line low while either pulse runs
    assign LINK.alert_out = 1'b0;
    assign LINK.alert_oe = (par_cnt_ff != 8'h00) || (crc_cnt_ff != 8'h00);

    // --------------------------------------
    // Write leveling feedback
    // --------------------------------------
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_B_I)
            dq_fb_ff <= 1'b0;
        else if (mode_ff[smt_pkg::MODE_WL_BIT] && dqs_rise)
            dq_fb_ff <= ck_s;
    end

    assign LINK.dq_fb = dq_fb_ff;
    assign LINK.dq_fb_oe = mode_ff[smt_pkg::MODE_WL_BIT];

    // --------------------------------------
    // User side event and data outputs
    // --------------------------------------
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_B_I)
        begin
            REF_PULSE_O <= 1'b0;
            WR_VALID_O <= 1'b0;
            WR_DATA_O <= 1'b0;
            PAR_ERR_O <= 1'b0;
            CRC_ERR_O <= 1'b0;
        end
        else
        begin
            REF_PULSE_O <= cmd_ok && cmd_s == smt_pkg::CMD_REF;
            WR_VALID_O <= cmd_ok && cmd_s == smt_pkg::CMD_WR;
            WR_DATA_O <= (cmd_ok && cmd_s == smt_pkg::CMD_WR) ? dqw_s : WR_DATA_O;
            PAR_ERR_O <= par_bad;
            CRC_ERR_O <= CRC_EN_I && cmd_ok && cmd_s == smt_pkg::CMD_WR && crc_s != dqw_s;
        end
    end

    assign WL_MODE_O = mode_ff[smt_pkg::MODE_WL_BIT];
    assign GEAR_MODE_O = mode_ff[smt_pkg::MODE_GEAR_BIT];
    assign PDA_MODE_O = mode_ff[smt_pkg::MODE_PDA_BIT];
    assign PERSIST_MODE_O = mode_ff[smt_pkg::MODE_PERSIST_BIT];
endmodule

// *** verilog/smt_ctrl.sv ***
`timescale 1ns/100ps
module smt_ctrl (
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    input wire logic REQ_VALID_I,
    input wire logic [2:0] REQ_OP_I,
    input wire logic [3:0] REQ_ADDR_I,
    input wire logic REQ_DATA_I,
    input wire logic REQ_BAD_PAR_I,
    input wire logic REQ_BAD_CRC_I,
    input wire logic HOT_I,
    input wire logic PERSIST_I,
    output logic REQ_READY_O,
    output logic WL_DONE_O,
    output logic WL_SAMPLE_O,
    output logic ALERT_SEEN_O,
    smt_link_if.ctrl LINK
);
    typedef enum logic [6:0] {
        ST_RESET = 7'h01,
        ST_INIT = 7'h02,
        ST_IDLE = 7'h04,
        ST_GAP = 7'h08,
        ST_WL = 7'h10,
        ST_GSYNC = 7'h20,
        ST_GCMD = 7'h40
    } smt_state_type;

    smt_state_type state_ff;
    logic [2:0] div_ff;
    logic ck_ff, cke_ff, slot_en;
    logic [7:0] cnt_ff;
    logic [7:0] mod_cnt_ff;
    logic [2:0] cmd_ff;
    logic [3:0] addr_ff;
    logic par_ff, dqw_ff, crc_ff, dqs_ff, dqs_oe_ff;
    logic [12:0] ref_cnt_ff;
    logic ref_due, alert_hold, take;
    logic [2:0] in_s;
    logic alert_n_s, fb_oe_s, dq_fb_s;
    logic [2:0] nxt_cmd;
    logic [3:0] nxt_addr;

    // --------------------------------------
    // Link clock divider, one slot per nCK
    // --------------------------------------
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_B_I)
        begin
            div_ff <= 3'h0;
            ck_ff <= 1'b0;
        end
        else
        begin
            div_ff <= (div_ff == 3'(smt_pkg::CK_DIV - 1)) ? 3'h0 : div_ff + 3'h1;
            ck_ff <= (div_ff == 3'(smt_pkg::CK_DIV - 1)) || (div_ff < 3'(smt_pkg::CK_HALF - 1));
        end
    end

    // Slot starts at the falling edge so pins are stable at the next rise
    assign slot_en = (div_ff == 3'(smt_pkg::CK_HALF - 1));

    // --------------------------------------
    // Alert and feedback sampling
    // --------------------------------------
    smt_sync #(.W(3), .RST_VAL(3'h4)) u_sync (
        .clk_i(CORE_CLK_I),
        .rst_b_i(RST_B_I),
        .d_i({LINK.alert_n, LINK.dq_fb_oe, LINK.dq_fb}),
        .q_o(in_s)
    );
    assign {alert_n_s, fb_oe_s, dq_fb_s} = in_s;
    assign ALERT_SEEN_O = !alert_n_s;
    // Persistent mode answers an alert with deselects from the next slot
    assign alert_hold = PERSIST_I && !alert_n_s;

    // --------------------------------------
    // Refresh interval timer in core cycles
    // --------------------------------------
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_B_I)
            ref_cnt_ff <= 13'h0000;
        else if (slot_en && state_ff == ST_IDLE && ref_due && !alert_hold)
            ref_cnt_ff <= 13'h0000;
        else if (!ref_due)
            ref_cnt_ff <= ref_cnt_ff + 13'h0001;
    end

    assign ref_due = ref_cnt_ff >= (HOT_I ? 13'(smt_pkg::TREFI_HOT_CYC - smt_pkg::TREFI_MARGIN_CYC)
                                          : 13'(smt_pkg::TREFI_NORM_CYC - smt_pkg::TREFI_MARGIN_CYC));

    // Requests taken in a free slot; all ops but OP_MRS_PDA also wait for the update delay
    assign take = slot_en && state_ff == ST_IDLE && !ref_due && !alert_hold && REQ_VALID_I
                  && (REQ_OP_I == smt_pkg::OP_MRS_PDA || mod_cnt_ff == 8'h00);
    assign REQ_READY_O = slot_en && state_ff == ST_IDLE && !ref_due && !alert_hold
                         && (REQ_OP_I == smt_pkg::OP_MRS_PDA || mod_cnt_ff == 8'h00);

    // --------------------------------------
    // Command choice for the slot
    // --------------------------------------
    always_comb
    begin
        nxt_cmd = smt_pkg::CMD_DES;
        nxt_addr = 4'h0;
        if (state_ff == ST_IDLE && !alert_hold && ref_due)
            nxt_cmd = smt_pkg::CMD_REF;
        else if (take)
        begin
            nxt_cmd = (REQ_OP_I == smt_pkg::OP_WR) ? smt_pkg::CMD_WR : smt_pkg::CMD_MRS;
            nxt_addr = REQ_ADDR_I;
            if (REQ_OP_I == smt_pkg::OP_WL)
                nxt_addr[smt_pkg::MODE_WL_BIT] = 1'b1;
            if (REQ_OP_I == smt_pkg::OP_GEAR)
                nxt_addr[smt_pkg::MODE_GEAR_BIT] = 1'b1;
        end
        else if (state_ff == ST_GSYNC && cnt_ff == 8'h00)
            nxt_cmd = smt_pkg::CMD_SYNC;
    end

    // --------------------------------------
    // Command pins, updated once per slot
    // --------------------------------------
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_B_I)
        begin
            cmd_ff <= smt_pkg::CMD_DES;
            addr_ff <= 4'h0;
            par_ff <= 1'b0;
            dqw_ff <= 1'b0;
            crc_ff <= 1'b0;
        end
        else if (slot_en)
        begin
            cmd_ff <= nxt_cmd;
            addr_ff <= nxt_addr;
            par_ff <= ^{nxt_cmd, nxt_addr} ^ (take && REQ_BAD_PAR_I);
            dqw_ff <= take ? REQ_DATA_I : 1'b0;
            crc_ff <= take ? (REQ_DATA_I ^ REQ_BAD_CRC_I) : 1'b0;
        end
    end

    // --------------------------------------
    // Sequencer
    // --------------------------------------
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_B_I)
        begin
            state_ff <= ST_RESET;
            cnt_ff <= 8'(smt_pkg::TCKE_LOW_NCK);
            cke_ff <= 1'b0;
        end
        else if (slot_en)
        begin
            case (state_ff)
                ST_RESET:
                begin
                    if (cnt_ff == 8'h00)
                    begin
                        cke_ff <= 1'b1;
                        cnt_ff <= 8'(smt_pkg::TXPR_NCK);
                        state_ff <= ST_INIT;
                    end
                    else
                        cnt_ff <= cnt_ff - 8'h01;
                end
                ST_INIT, ST_GAP:
                begin
                    if (cnt_ff == 8'h00)
                        state_ff <= ST_IDLE;
                    else
                        cnt_ff <= cnt_ff - 8'h01;
                end
                ST_IDLE:
                begin
                    if (!alert_hold && ref_due)
                    begin
                        cnt_ff <= 8'(smt_pkg::TRFC1_NCK - 1);
                        state_ff <= ST_GAP;
                    end
                    else if (take)
                    begin
                        case (REQ_OP_I)
                            smt_pkg::OP_MRS_PDA:
                            begin
                                cnt_ff <= 8'(smt_pkg::TMRD_PDA_NCK - 1);
                                state_ff <= ST_GAP;
                            end
                            smt_pkg::OP_WL:
                            begin
                                cnt_ff <= 8'h00;
                                state_ff <= ST_WL;
                            end
                            smt_pkg::OP_GEAR:
                            begin
                                cnt_ff <= 8'(smt_pkg::TSYNC_GEAR_NCK - 1);
                                state_ff <= ST_GSYNC;
                            end
                            default:
                            begin
                                cnt_ff <= 8'h00;
                                state_ff <= ST_GAP;
                            end
                        endcase
                    end
                end
                ST_WL:
                begin
                    if (cnt_ff == 8'(smt_pkg::TWLMRD_NCK + smt_pkg::TWL_FB_WAIT_NCK))
                        state_ff <= ST_IDLE;
                    else
                        cnt_ff <= cnt_ff + 8'h01;
                end
                ST_GSYNC:
                begin
                    if (cnt_ff == 8'h00)
                    begin
                        cnt_ff <= 8'(smt_pkg::TCMD_GEAR_NCK - 1);
                        state_ff <= ST_GCMD;
                    end
                    else
                        cnt_ff <= cnt_ff - 8'h01;
                end
                ST_GCMD:
                begin
                    if (cnt_ff == 8'h00)
                        state_ff <= ST_IDLE;
                    else
                        cnt_ff <= cnt_ff - 8'h01;
                end
                default:
                    state_ff <= ST_RESET;
            endcase
        end
    end

    // Update delay after every mode register set guards dependent commands
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_B_I)
            mod_cnt_ff <= 8'h00;
        else if (slot_en && nxt_cmd == smt_pkg::CMD_MRS)
            mod_cnt_ff <= 8'(smt_pkg::TMOD_NCK);
        else if (slot_en && mod_cnt_ff != 8'h00)
            mod_cnt_ff <= mod_cnt_ff - 8'h01;
    end

    // --------------------------------------
    // Write leveling strobe and result
    // --------------------------------------
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_B_I)
        begin
            dqs_ff <= 1'b0;
            dqs_oe_ff <= 1'b0;
            WL_DONE_O <= 1'b0;
            WL_SAMPLE_O <= 1'b0;
        end
        else
        begin
            WL_DONE_O <= 1'b0;
            if (slot_en)
            begin
                dqs_oe_ff <= (state_ff == ST_WL) && (cnt_ff >= 8'(smt_pkg::TWLDQSEN_NCK));
                dqs_ff <= (state_ff == ST_WL) && (cnt_ff == 8'(smt_pkg::TWLMRD_NCK));
                if (state_ff == ST_WL && cnt_ff == 8'(smt_pkg::TWLMRD_NCK + smt_pkg::TWL_FB_WAIT_NCK))
                begin
                    WL_DONE_O <= 1'b1;
                    WL_SAMPLE_O <= fb_oe_s && dq_fb_s;
                end
            end
        end
    end

    assign LINK.ck = ck_ff;
    assign LINK.cke = cke_ff;
    assign LINK.cmd = cmd_ff;
    assign LINK.addr = addr_ff;
    assign LINK.par = par_ff;
    assign LINK.dqs = dqs_ff;
    assign LINK.dqs_oe = dqs_oe_ff;
    assign LINK.dq_w = dqw_ff;
    assign LINK.crc = crc_ff;
endmodule

// *** dv/smt_link_chk.sv ***
`timescale 1ns/100ps
module smt_link_chk (
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    input wire logic ck,
    input wire logic cke,
    input wire logic [2:0] cmd,
    input wire logic [3:0] addr,
    input wire logic par,
    input wire logic dqs,
    input wire logic dqs_oe,
    input wire logic dq_w,
    input wire logic crc,
    input wire logic alert_n
);
    logic ck_d_ff;
    logic pda_ff;
    logic [7:0] gap_ff [5];
    logic [10:0] low_ff;
    wire rise = ck && !ck_d_ff;
    wire issue = rise && cmd != smt_pkg::CMD_DES;
    wire mrs = rise && cmd == smt_pkg::CMD_MRS;
    wire [4:0] hit = {!cke, rise && cmd == smt_pkg::CMD_SYNC, mrs && addr[1], mrs && addr[0], mrs};

    // Link clocks since any set, leveling, gear, sync and cke high; last set's per-device bit
    always_ff @(posedge CORE_CLK_I)
    begin
        ck_d_ff <= RST_B_I && ck;
        pda_ff <= RST_B_I && (mrs ? addr[2] : pda_ff);
        for (int i = 0; i < 5; i++)
        begin
            if (!RST_B_I)
                gap_ff[i] <= 8'hFF;
            else if (hit[i])
                gap_ff[i] <= 8'h00;
            else if (rise && gap_ff[i] != 8'hFF)
                gap_ff[i] <= gap_ff[i] + 8'h01;
        end
    end

    // Core cycles the alert line has been low
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_B_I || alert_n)
            low_ff <= 11'h000;
        else if (low_ff != 11'h7FF)
            low_ff <= low_ff + 11'h001;
    end

    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_B_I);

    pda_gap_a: assert property (mrs && pda_ff |-> gap_ff[0] >= smt_pkg::TMRD_PDA_NCK - 1)
        else $error("per-device sets too close");
    wl_strobe_a: assert property ($rose(dqs) |-> gap_ff[1] >= smt_pkg::TWLMRD_NCK)
        else $error("strobe rose too early");
    wl_enable_a: assert property ($rose(dqs_oe) |-> gap_ff[1] >= smt_pkg::TWLDQSEN_NCK)
        else $error("strobe driven too early");
    par_alert_a: assert property (issue && par != ^{cmd, addr} |-> ##[1:48] !alert_n)
        else $error("parity alert late");
    crc_alert_a: assert property (rise && cmd == smt_pkg::CMD_WR && crc != dq_w |-> ##[1:16] !alert_n)
        else $error("crc alert late");
    alert_width_a: assert property ($rose(alert_n) |-> low_ff inside {[48:80], [640:1536]})
        else $error("alert width out of range");
    reset_exit_a: assert property (issue |-> gap_ff[4] >= smt_pkg::TXPR_NCK - 1)
        else $error("command too soon after cke");
    sync_wait_a: assert property (hit[3] |-> gap_ff[2] >= smt_pkg::TSYNC_GEAR_NCK - 1)
        else $error("sync pulse too early");
    gear_cmd_a: assert property (issue && !hit[3] |-> gap_ff[3] >= smt_pkg::TCMD_GEAR_NCK - 1)
        else $error("command too soon after sync");
endmodule

// *** dv/sdram_mode_training_alert_timing_tb_top.sv ***
`timescale 1ns/100ps
module sdram_mode_training_alert_timing_tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic vld = 1'b0;
    logic [2:0] op = 3'h0;
    logic [3:0] ad = 4'h0;
    logic dat = 1'b0, bpar = 1'b0, bcrc = 1'b0, hot = 1'b0, pers = 1'b0, fast = 1'b0, sel = 1'b1;
    logic rdy, wl_done, wl_smp, seen, wl_mode, gr_mode, pda_mode, ps_mode, ref_p, wr_v, wr_d;
    int miscompares = 0;
    int checked = 0;
    int cyc = 0;
    int w;

    smt_link_if i_smt_link_if ();
    smt_ctrl i_smt_ctrl (.CORE_CLK_I(clk), .RST_B_I(rst_b), .REQ_VALID_I(vld), .REQ_OP_I(op), .REQ_ADDR_I(ad),
        .REQ_DATA_I(dat), .REQ_BAD_PAR_I(bpar), .REQ_BAD_CRC_I(bcrc), .HOT_I(hot), .PERSIST_I(pers),
        .REQ_READY_O(rdy), .WL_DONE_O(wl_done), .WL_SAMPLE_O(wl_smp), .ALERT_SEEN_O(seen), .LINK(i_smt_link_if));
    smt_dram i_smt_dram (.CORE_CLK_I(clk), .RST_B_I(rst_b), .PAR_EN_I(1'b1), .CRC_EN_I(1'b1), .FAST_GRADE_I(fast),
        .DEV_SEL_I(sel), .LINK(i_smt_link_if), .WL_MODE_O(wl_mode), .GEAR_MODE_O(gr_mode), .PDA_MODE_O(pda_mode),
        .PERSIST_MODE_O(ps_mode), .REF_PULSE_O(ref_p), .WR_VALID_O(wr_v), .WR_DATA_O(wr_d), .PAR_ERR_O(),
        .CRC_ERR_O());
    smt_link_chk i_smt_link_chk (.CORE_CLK_I(clk), .RST_B_I(rst_b), .ck(i_smt_link_if.ck), .cke(i_smt_link_if.cke),
        .cmd(i_smt_link_if.cmd), .addr(i_smt_link_if.addr), .par(i_smt_link_if.par), .dqs(i_smt_link_if.dqs),
        .dqs_oe(i_smt_link_if.dqs_oe), .dq_w(i_smt_link_if.dq_w), .crc(i_smt_link_if.crc),
        .alert_n(i_smt_link_if.alert_n));

    // Core clock and hang limit
    always #50 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            miscompares++;
            test_done();
        end
    end

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s exp %0h got %0h", n, e, g);
        end
    endtask

    task automatic nck(int n);
        repeat (n * smt_pkg::CK_DIV) @(negedge clk);
    endtask

    // Hold the request until a ready edge takes it
    task automatic req(logic [2:0] o, logic [3:0] a, logic d, logic bp, logic bc);
        op = o;
        ad = a;
        dat = d;
        bpar = bp;
        bcrc = bc;
        vld = 1'b1;
        while (rdy !== 1'b1) @(negedge clk);
        @(negedge clk);
        vld = 1'b0;
        @(negedge clk);
    endtask

    // Width of the next alert pulse in core cycles
    task automatic alert_w();
        w = 0;
        while (i_smt_link_if.alert_n !== 1'b0) @(negedge clk);
        while (i_smt_link_if.alert_n === 1'b0)
        begin
            @(negedge clk);
            w++;
        end
        chk("alert_seen", 1, seen);
    endtask

    task automatic test_done();
        if (miscompares == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        req(smt_pkg::OP_MRS_PDA, 4'h4, 0, 0, 0);
        nck(10);
        chk("pda_early", 0, pda_mode);
        nck(30);
        chk("pda_mode", 1, pda_mode);
        sel = 1'b0;
        req(smt_pkg::OP_MRS_PDA, 4'h0, 0, 0, 0);
        nck(30);
        chk("pda_kept", 1, pda_mode);
        sel = 1'b1;
        req(smt_pkg::OP_MRS_PDA, 4'h4, 0, 0, 0);
        req(smt_pkg::OP_MRS_PDA, 4'h0, 0, 0, 0);
        nck(40);
        chk("pda_exit", 0, pda_mode);
        req(smt_pkg::OP_WL, 4'h1, 0, 0, 0);
        w = 0;
        while (wl_done !== 1'b1)
        begin
            @(negedge clk);
            w++;
        end
        chk("wl_wait", 1, w >= smt_pkg::TWLMRD_NCK * smt_pkg::CK_DIV);
        chk("wl_mode", 1, wl_mode);
        chk("wl_sample", 0, wl_smp);
        req(smt_pkg::OP_MRS, 4'h0, 0, 0, 0);
        nck(40);
        req(smt_pkg::OP_WR, 4'h0, 1, 0, 0);
        while (wr_v !== 1'b1) @(negedge clk);
        chk("wr_data", 1, wr_d);
        req(smt_pkg::OP_WR, 4'h0, 0, 0, 1);
        alert_w();
        chk("crc_width", 1, w inside {[48:80]});
        // Slow, fast, then persistent; the leveling set must be dropped
        for (int g = 0; g < 3; g++)
        begin
            fast = (g == 1);
            pers = (g == 2);
            if (g == 2)
            begin
                req(smt_pkg::OP_MRS, 4'h8, 0, 0, 0);
                nck(40);
                chk("persist", 1, ps_mode);
            end
            req(smt_pkg::OP_MRS, (g == 2) ? 4'h9 : 4'h1, 0, 1, 0);
            alert_w();
            chk("par_width", 1, w >= (g == 1 ? 768 : 640) && w <= (g == 1 ? 1536 : 1280));
            chk("dropped", 0, wl_mode);
        end
        req(smt_pkg::OP_MRS, 4'h0, 0, 0, 0);
        req(smt_pkg::OP_GEAR, 4'h2, 0, 0, 0);
        req(smt_pkg::OP_MRS, 4'h2, 0, 0, 0);
        chk("gear_mode", 1, gr_mode);
        for (int h = 0; h < 2; h++)
        begin
            hot = h[0];
            w = 0;
            repeat (4000)
            begin
                @(negedge clk);
                w += (ref_p === 1'b1);
            end
            chk("refresh", 1, w >= 4000 / (h ? smt_pkg::TREFI_HOT_CYC : smt_pkg::TREFI_NORM_CYC) - 1);
        end
        test_done();
    end
endmodule
